/* File: pes_core_model.sv */
// Purpose: core pipeline stand-in that pulses occurrence lines
// Assumes: the bench sets a pattern just after a rising edge
// Notes: lines go back to zero between occurrences
module pes_core_model (
    input wire clk,
    input wire [16:0] pat,
    output reg [16:0] ev
);
    timeunit 1ns;
    timeprecision 1ps;
    initial ev = 17'h0_0000;
    always @(posedge clk) begin
        ev <= #1 pat;
    end
endmodule // pes_core_model

/* File: pes_defs.vh */
// Purpose: constants for the performance event selector
// Assumes: 40 MHz core clock, synchronous active-high reset
// Notes: event codes and unit masks are eight bits each
// Functional notes
// RQ1: code CA mask 08 counts scalar-double compute
// RQ2: compute count excludes loads, stores, logicals
// RQ3: code CB mask 01 counts second-level hits
// RQ4: code CB mask 02 counts second-level misses
// RQ5: code CB mask 04 counts non-faulting translation misses
// RQ6: load events are precise, tied to retiring load
// RQ7: code CD mask 00 counts state-clear assists
// RQ8: assists also from denormal or underflow cases
// RQ9: code CE mask 00 counts retired vector instructions
// RQ10: code CF mask 00 counts saturating vector retires
// RQ11: code E0 mask 01 counts decoded branches
// RQ12: code E4 mask 01 counts false taken branches
// RQ13: code E6 mask 01 counts front-end redirects
// RQ14: each redirect costs about seven fetch cycles
// RQ15: match both fields, increment by one
`ifndef PES_DEFS_VH
`define PES_DEFS_VH

`define PES_CODE_W 8
`define PES_CNT_W 40
`define PES_EV_SCALAR_DBL 8'hCA
`define PES_MK_SCALAR_DBL 8'h08
`define PES_EV_LOAD 8'hCB
`define PES_MK_L2_HIT 8'h01
`define PES_MK_L2_MISS 8'h02
`define PES_MK_XLAT_MISS 8'h04
`define PES_EV_ASSIST 8'hCD
`define PES_EV_VEC_RET 8'hCE
`define PES_EV_SAT_RET 8'hCF
`define PES_EV_BR_DEC 8'hE0
`define PES_EV_FALSE_BR 8'hE4
`define PES_EV_REDIRECT 8'hE6
`define PES_MK_NONE 8'h00
`define PES_MK_ONE 8'h01
`define PES_NUM_EV 10
`define PES_REDIRECT_PENALTY 3'h7
`define PES_PENALTY_W 3

`endif

/* File: pes_qualify.v */
// Purpose: qualifies raw pipeline occurrences into countable events
// Assumes: all inputs synchronous to clk, one-cycle pulses
// Notes: purely combinational, registered in the top module
module pes_qualify (
    input wire retire_vec_valid,
    input wire retire_vec_scalar_dbl,
    input wire retire_vec_arith,
    input wire retire_vec_saturating,
    input wire retire_load_valid,
    input wire retire_load_fault,
    input wire retire_load_l1_miss,
    input wire retire_load_l2_hit,
    input wire retire_load_xlat_miss,
    input wire state_clear_after_mm,
    input wire denormal_input,
    input wire underflow_result,
    input wire denormals_as_zero_flag,
    input wire flush_underflow_flag,
    output wire scalar_dbl_compute_event,
    output wire retired_load_second_level_hit,
    output wire retired_load_second_level_miss,
    output wire retired_load_translation_miss,
    output wire vector_assist_event,
    output wire vector_retired_event,
    output wire saturating_vector_retired_event
);
    // ***************************************************
    // vector instruction qualification
    // ***************************************************
    // RQ2: arithmetic ops only
    assign scalar_dbl_compute_event = retire_vec_valid & retire_vec_scalar_dbl & retire_vec_arith;
    assign vector_retired_event = retire_vec_valid;
    assign saturating_vector_retired_event = retire_vec_valid & retire_vec_saturating;

    // ***************************************************
    // retired load qualification
    // ***************************************************
    // RQ6: per retiring load
    assign retired_load_second_level_hit = retire_load_valid & retire_load_l1_miss & retire_load_l2_hit;
    assign retired_load_second_level_miss = retire_load_valid & retire_load_l1_miss & ~retire_load_l2_hit;
    // RQ5: faulting loads dropped
    assign retired_load_translation_miss = retire_load_valid & retire_load_xlat_miss & ~retire_load_fault;

    // ***************************************************
    // assist qualification
    // ***************************************************
    // RQ8: denormal and underflow assists
    assign vector_assist_event = state_clear_after_mm | (denormal_input & ~denormals_as_zero_flag) |
                                 (underflow_result & ~flush_underflow_flag);
endmodule // pes_qualify

/* File: pes_selector.v */
// Purpose: selects one performance event by code and unit mask and counts it
// Assumes: one clock, synchronous reset, core signals synchronous pulses
// Notes: at most one increment per cycle; unmatched selections never count
`include "pes_defs.vh"
module pes_selector (
    input wire clk,
    input wire reset,
    input wire [`PES_CODE_W-1:0] event_code,
    input wire [`PES_CODE_W-1:0] unit_mask,
    input wire counter_enable,
    input wire counter_clear,
    input wire retire_vec_valid,
    input wire retire_vec_scalar_dbl,
    input wire retire_vec_arith,
    input wire retire_vec_saturating,
    input wire retire_load_valid,
    input wire retire_load_fault,
    input wire retire_load_l1_miss,
    input wire retire_load_l2_hit,
    input wire retire_load_xlat_miss,
    input wire state_clear_after_mm,
    input wire denormal_input,
    input wire underflow_result,
    input wire denormals_as_zero_flag,
    input wire flush_underflow_flag,
    input wire branch_decoded_event,
    input wire false_taken_branch_event,
    input wire front_end_redirect_event,
    output reg [`PES_CNT_W-1:0] count,
    output reg count_pulse,
    output reg fetch_stall,
    output reg branch_target_buffer_flush
);
    wire scalar_dbl_ev;
    wire l2_hit_ev;
    wire l2_miss_ev;
    wire xlat_miss_ev;
    wire assist_ev;
    wire vec_ret_ev;
    wire sat_ret_ev;
    reg [`PES_NUM_EV-1:0] match;
    reg [`PES_NUM_EV-1:0] occur;
    wire hit;
    reg [`PES_PENALTY_W-1:0] stall_reg;
    reg [`PES_PENALTY_W-1:0] stall_next;

    pes_qualify u_qualify (
        .retire_vec_valid(retire_vec_valid),
        .retire_vec_scalar_dbl(retire_vec_scalar_dbl),
        .retire_vec_arith(retire_vec_arith),
        .retire_vec_saturating(retire_vec_saturating),
        .retire_load_valid(retire_load_valid),
        .retire_load_fault(retire_load_fault),
        .retire_load_l1_miss(retire_load_l1_miss),
        .retire_load_l2_hit(retire_load_l2_hit),
        .retire_load_xlat_miss(retire_load_xlat_miss),
        .state_clear_after_mm(state_clear_after_mm),
        .denormal_input(denormal_input),
        .underflow_result(underflow_result),
        .denormals_as_zero_flag(denormals_as_zero_flag),
        .flush_underflow_flag(flush_underflow_flag),
        .scalar_dbl_compute_event(scalar_dbl_ev),
        .retired_load_second_level_hit(l2_hit_ev),
        .retired_load_second_level_miss(l2_miss_ev),
        .retired_load_translation_miss(xlat_miss_ev),
        .vector_assist_event(assist_ev),
        .vector_retired_event(vec_ret_ev),
        .saturating_vector_retired_event(sat_ret_ev)
    );

    // ***************************************************
    // event selection
    // ***************************************************
    always @* begin
        // RQ1: scalar double compute
        match[0] = (event_code == `PES_EV_SCALAR_DBL) && (unit_mask == `PES_MK_SCALAR_DBL);
        occur[0] = scalar_dbl_ev;
        // RQ3: second-level hit
        match[1] = (event_code == `PES_EV_LOAD) && (unit_mask == `PES_MK_L2_HIT);
        occur[1] = l2_hit_ev;
        // RQ4: second-level miss
        match[2] = (event_code == `PES_EV_LOAD) && (unit_mask == `PES_MK_L2_MISS);
        occur[2] = l2_miss_ev;
        // RQ5: translation miss
        match[3] = (event_code == `PES_EV_LOAD) && (unit_mask == `PES_MK_XLAT_MISS);
        occur[3] = xlat_miss_ev;
        // RQ7: vector assists
        match[4] = (event_code == `PES_EV_ASSIST) && (unit_mask == `PES_MK_NONE);
        occur[4] = assist_ev;
        // RQ9: vector retired
        match[5] = (event_code == `PES_EV_VEC_RET) && (unit_mask == `PES_MK_NONE);
        occur[5] = vec_ret_ev;
        // RQ10: saturating retired
        match[6] = (event_code == `PES_EV_SAT_RET) && (unit_mask == `PES_MK_NONE);
        occur[6] = sat_ret_ev;
        // RQ11: decoded branches
        match[7] = (event_code == `PES_EV_BR_DEC) && (unit_mask == `PES_MK_ONE);
        occur[7] = branch_decoded_event;
        // RQ12: false taken branches
        match[8] = (event_code == `PES_EV_FALSE_BR) && (unit_mask == `PES_MK_ONE);
        occur[8] = false_taken_branch_event;
        // RQ13: front-end redirects
        match[9] = (event_code == `PES_EV_REDIRECT) && (unit_mask == `PES_MK_ONE);
        occur[9] = front_end_redirect_event | false_taken_branch_event;
    end

    // RQ15: both fields must match
    assign hit = |(match & occur);

    // ***************************************************
    // redirect penalty window
    // ***************************************************
    always @* begin
        stall_next = stall_reg;
        // RQ14: seven lost fetch cycles
        if (front_end_redirect_event || false_taken_branch_event) begin
            stall_next = `PES_REDIRECT_PENALTY;
        end else if (stall_reg != {`PES_PENALTY_W{1'b0}}) begin
            stall_next = stall_reg - 1'b1;
        end
    end

    // ***************************************************
    // counter and registered outputs
    // ***************************************************
    always @(posedge clk) begin
        if (reset) begin
            count <= {`PES_CNT_W{1'b0}};
            count_pulse <= 1'b0;
            stall_reg <= {`PES_PENALTY_W{1'b0}};
            fetch_stall <= 1'b0;
            branch_target_buffer_flush <= 1'b0;
        end else begin
            stall_reg <= stall_next;
            fetch_stall <= (stall_next != {`PES_PENALTY_W{1'b0}});
            // RQ12: false branch flushes buffer
            branch_target_buffer_flush <= false_taken_branch_event;
            // RQ15: clear suppresses pulse
            count_pulse <= counter_enable & ~counter_clear & hit;
            // RQ15: increment by one
            if (counter_clear) begin
                count <= {`PES_CNT_W{1'b0}};
            end else if (counter_enable && hit) begin
                count <= count + 1'b1;
            end
        end
    end
endmodule // pes_selector

/* File: pes_selector_sva.sv */
// Purpose: port checks for the event selector
// Assumes: one clock, synchronous active-high reset
// Notes: attached by bind below the module
`include "pes_defs.vh"
module pes_selector_chk (
    input wire clk, reset, counter_enable, counter_clear,
    input wire [7:0] event_code, unit_mask,
    input wire retire_vec_valid, retire_vec_scalar_dbl, retire_vec_arith, retire_load_fault,
    input wire branch_decoded_event, false_taken_branch_event, front_end_redirect_event,
    input wire [39:0] count,
    input wire count_pulse, fetch_stall, branch_target_buffer_flush
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    wire go = counter_enable & ~counter_clear;
    wire [15:0] sel = {event_code, unit_mask};
    property p_inc; count_pulse |-> count == $past(count) + 40'h1; endproperty
    a_inc: assert property (p_inc) else $error("count step wrong");
    property p_clr; counter_clear |=> count == 40'h0 && !count_pulse; endproperty
    a_clr: assert property (p_clr) else $error("clear ignored");
    property p_sd; go && sel == 16'hCA08 && retire_vec_valid && retire_vec_scalar_dbl && retire_vec_arith
        |=> count_pulse; endproperty
    a_sd: assert property (p_sd) else $error("scalar double missed");
    property p_arith; sel == 16'hCA08 && !retire_vec_arith |=> !count_pulse; endproperty
    a_arith: assert property (p_arith) else $error("non arithmetic counted");
    property p_fault; sel == 16'hCB04 && retire_load_fault |=> !count_pulse; endproperty
    a_fault: assert property (p_fault) else $error("faulting miss counted");
    property p_vec; go && sel == 16'hCE00 && retire_vec_valid |=> count_pulse; endproperty
    a_vec: assert property (p_vec) else $error("vector retire missed");
    property p_brd; go && sel == 16'hE001 && branch_decoded_event |=> count_pulse; endproperty
    a_brd: assert property (p_brd) else $error("decoded branch missed");
    property p_flush; false_taken_branch_event |=> branch_target_buffer_flush; endproperty
    a_flush: assert property (p_flush) else $error("no flush");
    property p_redir; go && sel == 16'hE601 && front_end_redirect_event |=> count_pulse; endproperty
    a_redir: assert property (p_redir) else $error("redirect missed");
    property p_stall; front_end_redirect_event |=> fetch_stall [*7]; endproperty
    a_stall: assert property (p_stall) else $error("stall too short");
    c_pulse: cover property (count_pulse);
    c_flush: cover property (branch_target_buffer_flush);
    c_stall: cover property ($rose(fetch_stall));
endmodule // pes_selector_chk
bind pes_selector pes_selector_chk i_chk (.clk, .reset, .counter_enable, .counter_clear, .event_code,
    .unit_mask, .retire_vec_valid, .retire_vec_scalar_dbl, .retire_vec_arith, .retire_load_fault,
    .branch_decoded_event, .false_taken_branch_event, .front_end_redirect_event, .count, .count_pulse,
    .fetch_stall, .branch_target_buffer_flush);

/* File: tb.sv */
// Purpose: self-checking bench for the event selector
// Assumes: 40 MHz clk, reset high for 20 cycles
// Notes: occurrences are pulsed by pes_core_model
`include "pes_defs.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    reg clk = 1'b0, reset = 1'b1, counter_enable = 1'b1, counter_clear = 1'b0;
    reg [7:0] event_code = 8'h00, unit_mask = 8'h00;
    reg [16:0] pat = 17'h0_0000;
    wire [16:0] ev;
    wire [39:0] count;
    wire count_pulse, fetch_stall, branch_target_buffer_flush;
    integer failures = 0, checks_done = 0, i;
    always #12.5 clk = ~clk;
    pes_core_model i_pes_core_model (.clk(clk), .pat(pat), .ev(ev));
    pes_selector i_pes_selector (.clk(clk), .reset(reset), .event_code(event_code), .unit_mask(unit_mask),
        .counter_enable(counter_enable), .counter_clear(counter_clear), .retire_vec_valid(ev[0]),
        .retire_vec_scalar_dbl(ev[1]), .retire_vec_arith(ev[2]), .retire_vec_saturating(ev[3]),
        .retire_load_valid(ev[4]), .retire_load_fault(ev[5]), .retire_load_l1_miss(ev[6]),
        .retire_load_l2_hit(ev[7]), .retire_load_xlat_miss(ev[8]), .state_clear_after_mm(ev[9]),
        .denormal_input(ev[10]), .underflow_result(ev[11]), .denormals_as_zero_flag(ev[12]),
        .flush_underflow_flag(ev[13]), .branch_decoded_event(ev[14]), .false_taken_branch_event(ev[15]),
        .front_end_redirect_event(ev[16]), .count(count), .count_pulse(count_pulse),
        .fetch_stall(fetch_stall), .branch_target_buffer_flush(branch_target_buffer_flush));
    task check(input [39:0] nm, input [39:0] seen, exp);
        begin
            checks_done = checks_done + 1;
            if (seen !== exp) begin
                failures = failures + 1;
                $display("Error %0s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task trial(input [15:0] sel, input [16:0] p, input inc);
        reg [39:0] c0;
        begin
            {event_code, unit_mask} = sel;
            c0 = count;
            @(posedge clk) #1 pat = p;
            @(posedge clk) #1 pat = 17'h0_0000;
            @(posedge clk) #1 check("count", count, c0 + inc);
            check("pulse", {39'h0, count_pulse}, {39'h0, inc});
        end
    endtask
    task t_vector;
        begin
            trial(16'hCA08, 17'h0_0007, 1'b1);
            trial(16'hCA08, 17'h0_0003, 1'b0);
            trial(16'hCE00, 17'h0_0001, 1'b1);
            trial(16'hCF00, 17'h0_0009, 1'b1);
            trial(16'hCF00, 17'h0_0001, 1'b0);
            $display("vector test end");
        end
    endtask
    task t_load;
        begin
            trial(16'hCB01, 17'h0_00D0, 1'b1);
            trial(16'hCB02, 17'h0_00D0, 1'b0);
            trial(16'hCB02, 17'h0_0050, 1'b1);
            trial(16'hCB04, 17'h0_0110, 1'b1);
            trial(16'hCB04, 17'h0_0130, 1'b0);
            trial(16'hCB01, 17'h0_00C0, 1'b0);
            $display("load test end");
        end
    endtask
    task t_assist;
        begin
            trial(16'hCD00, 17'h0_0200, 1'b1);
            trial(16'hCD00, 17'h0_0400, 1'b1);
            trial(16'hCD00, 17'h0_1400, 1'b0);
            trial(16'hCD00, 17'h0_0800, 1'b1);
            trial(16'hCD00, 17'h0_2800, 1'b0);
            $display("assist test end");
        end
    endtask
    task t_branch;
        begin
            trial(16'hE001, 17'h0_4000, 1'b1);
            trial(16'hE401, 17'h0_8000, 1'b1);
            check("flush", {39'h0, branch_target_buffer_flush}, 40'h1);
            trial(16'hE601, 17'h1_0000, 1'b1);
            for (i = 0; i < 6; i = i + 1) @(posedge clk) #1 check("stall", {39'h0, fetch_stall}, 40'h1);
            @(posedge clk) #1 check("stall", {39'h0, fetch_stall}, 40'h0);
            trial(16'hE601, 17'h0_8000, 1'b1);
            $display("branch test end");
        end
    endtask
    task t_refuse;
        begin
            trial(16'hCA01, 17'h0_0007, 1'b0);
            trial(16'hE000, 17'h0_4000, 1'b0);
            counter_enable = 1'b0;
            trial(16'hCE00, 17'h0_0001, 1'b0);
            counter_enable = 1'b1;
            counter_clear = 1'b1;
            @(posedge clk) #1 check("count", count, 40'h0);
            trial(16'hCE00, 17'h0_0001, 1'b0);
            counter_clear = 1'b0;
            $display("refuse test end");
        end
    endtask
    task end_sim;
        begin
            $display("checks %0d failures %0d", checks_done, failures);
            if (failures == 0 && checks_done > 0) $display("Run complete: PASS");
            else $display("Run complete: FAIL");
            $finish;
        end
    endtask
    initial begin
        repeat (20) @(posedge clk);
        #1 reset = 1'b0;
        check("count", count, 40'h0);
        t_vector;
        t_load;
        t_assist;
        t_branch;
        t_refuse;
        end_sim;
    end
    initial begin
        #20000;
        failures = failures + 1;
        end_sim;
    end
endmodule // tb
